//--- logic/fieb_enable_bank.sv
// Fault-interrupt enable bank: three enable registers and the gated interrupt request
`timescale 1ns/1ps

module fieb_enable_bank (
  input wire logic clk_sys, // 50 MHz core clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire fieb_pkg::fieb_req_t req, // Register access request
  input wire logic [15:0] fault_latched, // Latched faults in enable-vector order
  output fieb_pkg::fieb_rsp_t rsp, // Register access answer
  output logic [15:0] irq_enable, // Current enable of each field
  output logic irq_req // Gated interrupt request
);
  import fieb_pkg::*;

  typedef struct packed {
    logic [15:0] en;
    logic [1:0] rsv_mb;
    logic [7:0] rsv_lf_hi;
    logic [5:0] rsv_lf_lo;
    fieb_rsp_t rsp;
    logic irq;
  } fieb_state_t;

  localparam fieb_state_t ST_RESET = '{
    en: RST_EN,
    rsv_mb: RST_RSV_MB,
    rsv_lf_hi: RST_RSV_LF_HI,
    rsv_lf_lo: RST_RSV_LF_LO,
    rsp: '0,
    irq: 1'b0
  };

  fieb_state_t st;
  fieb_state_t next_st;
  logic [1:0] sel;
  logic [15:0] rd_word;
  logic [1:0] code;

  // Address decode to a register index
  always_comb begin
    unique case (req.addr)
      OFS_SUPPLY_PUMP: sel = IDX_SUPPLY_PUMP;
      OFS_MASTER_BOOST: sel = IDX_MASTER_BOOST;
      OFS_LED_FAULT: sel = IDX_LED_FAULT;
      default: sel = IDX_NONE;
    endcase
  end

  always_comb begin
    next_st = st;
    rd_word = RD_UNMAPPED;
    code = CODE_RD_OFF;
    // Read image from the state before this access
    for (int i = 0; i < NUM_FIELDS; i++) begin
      if (FLD_REG[i] == sel) begin
        rd_word[FLD_LSB[i] +: 2] = st.en[i] ? CODE_RD_ON : CODE_RD_OFF;
      end
    end
    if (sel == IDX_MASTER_BOOST) begin
      rd_word[RSV_MB_LSB +: 2] = st.rsv_mb;
    end
    if (sel == IDX_LED_FAULT) begin
      rd_word[RSV_LF_HI_LSB +: 8] = st.rsv_lf_hi;
      rd_word[RSV_LF_LO_LSB +: 6] = st.rsv_lf_lo;
    end
    // Field writes are set/clear codes, so one write can touch a subset of fields
    if (req.strobe && req.write) begin
      for (int i = 0; i < NUM_FIELDS; i++) begin
        if (FLD_REG[i] == sel) begin
          code = req.wdata[FLD_LSB[i] +: 2];
          if (code == CODE_WR_ON) begin
            next_st.en[i] = 1'b1;
          end else if (code == CODE_WR_OFF) begin
            next_st.en[i] = 1'b0;
          end else begin
            next_st.en[i] = st.en[i];
          end
        end
      end
      // Reserved bits are plain storage; the host is expected to write zero
      if (sel == IDX_MASTER_BOOST) begin
        next_st.rsv_mb = req.wdata[RSV_MB_LSB +: 2];
      end
      if (sel == IDX_LED_FAULT) begin
        next_st.rsv_lf_hi = req.wdata[RSV_LF_HI_LSB +: 8];
        next_st.rsv_lf_lo = req.wdata[RSV_LF_LO_LSB +: 6];
      end
    end
    // Every strobe gets one answer; unmapped reads return zero with hit low
    next_st.rsp.valid = req.strobe;
    next_st.rsp.hit = req.strobe && (sel != IDX_NONE);
    next_st.rsp.rdata = (req.strobe && !req.write) ? rd_word : RD_UNMAPPED;
    // Request falls once the status side clears the latch, so no local clear path
    next_st.irq = st.en[EN_MASTER] && |(fault_latched & st.en & SRC_MASK);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign irq_enable = st.en;
  assign irq_req = st.irq;

endmodule : fieb_enable_bank

//--- shared/fieb_pkg.sv
// Register map, field layout and port carriers of the fault-interrupt enable bank
package fieb_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] OFS_SUPPLY_PUMP = 8'h4E;
  localparam logic [7:0] OFS_MASTER_BOOST = 8'h50;
  localparam logic [7:0] OFS_LED_FAULT = 8'h52;

  // Register indices used by the field table
  localparam logic [1:0] IDX_SUPPLY_PUMP = 2'h0;
  localparam logic [1:0] IDX_MASTER_BOOST = 2'h1;
  localparam logic [1:0] IDX_LED_FAULT = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;

  // Register reset values as seen on a read
  localparam logic [15:0] RST_SUPPLY_PUMP = 16'h200A;
  localparam logic [15:0] RST_MASTER_BOOST = 16'hA02A;
  localparam logic [15:0] RST_LED_FAULT = 16'h0080;

  // Two-bit field codes
  localparam logic [1:0] CODE_RD_OFF = 2'h0;
  localparam logic [1:0] CODE_RD_ON = 2'h2;
  localparam logic [1:0] CODE_WR_OFF = 2'h1;
  localparam logic [1:0] CODE_WR_ON = 2'h3;

  // Enable vector layout: one bit per two-bit field
  localparam int NUM_FIELDS = 16;
  localparam int EN_INPUT_UV = 0;
  localparam int EN_INPUT_OV = 1;
  localparam int EN_BAD_STRING = 2;
  localparam int EN_FREQ_RES = 3;
  localparam int EN_PUMP_FAULT = 4;
  localparam int EN_PUMP_CAP = 5;
  localparam int EN_INPUT_OC = 6;
  localparam int EN_SYNC_LOSS = 7;
  localparam int EN_THERMAL = 8;
  localparam int EN_CORE_UVLO = 9;
  localparam int EN_BOOST_OC = 10;
  localparam int EN_BOOST_OVL = 11;
  localparam int EN_TEMP_WARN = 12;
  localparam int EN_BOOST_OVH = 13;
  localparam int EN_MASTER = 14;
  localparam int EN_LED = 15;

  // Register and low bit of each field, in enable-vector order
  localparam logic [1:0] FLD_REG [NUM_FIELDS] = '{
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
  localparam logic [3:0] FLD_LSB [NUM_FIELDS] = '{
    4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE,
    4'h0, 4'h2, 4'h4, 4'h6, 4'hA, 4'hC, 4'hE, 4'h6};

  // Reset state of the enable vector, matching the register reset values
  localparam logic [15:0] RST_EN = 16'hE743;
  // Sources that can raise the interrupt: every field but the master
  localparam logic [15:0] SRC_MASK = 16'hBFFF;

  // Reserved bits that are stored and read back
  localparam int RSV_MB_LSB = 8;
  localparam int RSV_LF_HI_LSB = 8;
  localparam int RSV_LF_LO_LSB = 0;
  localparam logic [1:0] RST_RSV_MB = 2'h0;
  localparam logic [7:0] RST_RSV_LF_HI = 8'h00;
  localparam logic [5:0] RST_RSV_LF_LO = 6'h00;
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;

  typedef struct packed {
    logic strobe;
    logic write;
    logic [7:0] addr;
    logic [15:0] wdata;
  } fieb_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [15:0] rdata;
  } fieb_rsp_t;

endpackage : fieb_pkg

//--- sim/fieb_assertions.sv
// Port checks for the enable bank
`timescale 1ns/1ps
module fieb_assertions (
  input wire logic clk_sys, // Clock
  input wire logic arst_n, // Reset
  input wire fieb_pkg::fieb_req_t req, // Request
  input wire logic [15:0] fault_latched, // Faults
  input wire fieb_pkg::fieb_rsp_t rsp, // Answer
  input wire logic [15:0] irq_enable, // Enables
  input wire logic irq_req // Interrupt
);
  import fieb_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic wr = req.strobe && req.write;
  chk_answer_next: assert property (req.strobe |=> rsp.valid) else $error("no answer");
  chk_no_stray: assert property (!req.strobe |=> !rsp.valid && rsp.rdata == 16'h0000) else $error("stray");
  chk_master_off: assert property (wr && req.addr == 8'h50 && req.wdata[15:14] == 2'h1 |=>
    !irq_enable[14] ##1 !irq_req) else $error("master off");
  chk_set_code: assert property (wr && req.addr == 8'h4E && req.wdata[1:0] == 2'h3 |=> irq_enable[0])
    else $error("set");
  chk_keep_code: assert property (wr && req.addr == 8'h4E && !req.wdata[0] |=> $stable(irq_enable[0]))
    else $error("keep");
  chk_read_code: assert property (req.strobe && !req.write && req.addr == 8'h4E |=>
    rsp.rdata[1:0] == {$past(irq_enable[0]), 1'b0}) else $error("read code");
  chk_unmapped_read: assert property (req.strobe && !(req.addr inside {8'h4E, 8'h50, 8'h52}) |=>
    !rsp.hit && rsp.rdata == 16'h0000) else $error("unmapped");
  chk_idle_hold: assert property (!wr |=> $stable(irq_enable)) else $error("hold");
  chk_irq_gate: assert property ($past(arst_n) |->
    irq_req == $past(irq_enable[14] && |(fault_latched & irq_enable & 16'hBFFF))) else $error("gate");
  chk_reset_state: assert property (disable iff (1'b0) !arst_n |-> irq_enable == 16'hE743 && !irq_req)
    else $error("reset");
  cover property (wr && req.addr == 8'h52);
  cover property ($rose(irq_req));
  cover property (rsp.valid && !rsp.hit);
endmodule : fieb_assertions
bind fieb_enable_bank fieb_assertions u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .req(req),
  .fault_latched(fault_latched), .rsp(rsp), .irq_enable(irq_enable), .irq_req(irq_req));

//--- sim/fieb_fault_model.sv
// Fault latches standing beside the bank
`timescale 1ns/1ps
module fieb_fault_model (
  input wire logic clk_sys, // Clock
  input wire logic arst_n, // Reset
  input wire logic [15:0] raise, // Fault events
  input wire logic [15:0] st_wr, // Status bits written one
  input wire logic [15:0] cl_wr, // Clear bits written one
  output logic [15:0] latched // Latched faults
);
  // A status one alone must not clear: both bits are needed
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) latched <= 16'h0000;
    else latched <= (latched & ~(st_wr & cl_wr)) | raise;
  end
endmodule : fieb_fault_model

//--- sim/tb.sv
// Self-checking bench for the enable bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s %h %h", n, e, g); end end
module tb;
  import fieb_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b1;
  fieb_req_t req = '0;
  fieb_rsp_t rsp;
  logic [15:0] irq_enable, fault_latched;
  logic [15:0] raise = '0, st_wr = '0, cl_wr = '0;
  logic irq_req;
  int err_total = 0, tests_run = 0;
  fieb_enable_bank u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .fault_latched(fault_latched),
    .rsp(rsp), .irq_enable(irq_enable), .irq_req(irq_req));
  fieb_fault_model u_faults (.clk_sys(clk_sys), .arst_n(arst_n), .raise(raise), .st_wr(st_wr),
    .cl_wr(cl_wr), .latched(fault_latched));
  initial begin forever #10 clk_sys = ~clk_sys; end
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge clk_sys);
    req <= '{1'b1, w, a, d};
    @(posedge clk_sys);
    req.strobe <= 1'b0;
    #1;
    `CHK("valid", 1'b1, rsp.valid)
    `CHK("hit", a inside {OFS_SUPPLY_PUMP, OFS_MASTER_BOOST, OFS_LED_FAULT}, rsp.hit)
    if (!w) `CHK("rdata", e, rsp.rdata)
  endtask : acc
  // Fault latch lands one edge after raise, the request one edge later
  task automatic fault(input logic [15:0] r, input logic [15:0] c, input logic e);
    @(posedge clk_sys);
    {raise, st_wr, cl_wr} <= {r, c, c};
    @(posedge clk_sys);
    {raise, st_wr, cl_wr} <= '0;
    @(posedge clk_sys);
    #1;
    `CHK("irq", e, irq_req)
  endtask : fault
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    // A real falling edge, so the bank's state is reset before the first clock edge
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    acc(0, 8'h4E, 0, 16'h200A);
    acc(0, 8'h50, 0, 16'hA02A);
    acc(0, 8'h52, 0, 16'h0080);
    acc(1, 8'h4E, 16'hFFFF, 0);
    acc(1, 8'h4E, 16'hAAAA, 0);
    acc(0, 8'h4E, 0, 16'hAAAA);
    acc(1, 8'h4E, 16'h5555, 0);
    acc(0, 8'h4E, 0, 16'h0000);
    acc(1, 8'h50, 16'h0301, 0);
    acc(0, 8'h50, 0, 16'hA328);
    acc(0, 8'h60, 0, 16'h0000);
    fault(16'h8000, 0, 1);
    acc(1, 8'h50, 16'h4000, 0);
    fault(0, 0, 0);
    acc(1, 8'h50, 16'hC000, 0);
    fault(0, 0, 1);
    fault(0, 16'h8000, 0);
    fault(16'h0001, 0, 0);
    end_sim();
  end
  initial begin
    #20us;
    err_total++;
    end_sim();
  end
endmodule : tb
